// ---- logic/oled_link_pkg.sv ----
package oled_link_pkg;

  // link styles, value is {select high, select low}
  localparam logic [1:0] MODE_SPI4  = 2'h0;
  localparam logic [1:0] MODE_SPI3  = 2'h1;
  localparam logic [1:0] MODE_P8080 = 2'h2;
  localparam logic [1:0] MODE_P6800 = 2'h3;

  localparam logic [3:0] SPI4_LAST = 4'h7;
  localparam logic [3:0] SPI3_LAST = 4'h8;
  localparam logic [3:0] SPI4_BITS = 4'h8;
  localparam logic [3:0] SPI3_BITS = 4'h9;

  // host timing
  localparam int CLK_MHZ   = 20;
  localparam int STROBE_NS = 600;
  localparam int HALF_NS   = 300;
  localparam int GAP_NS    = 400;
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] HALF_CYC = 4'((HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] GAP_CYC  = 4'((GAP_NS * CLK_MHZ + 999) / 1000);

  // host register map, word addresses
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_XFER   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_RXDATA = 2'h3;
  localparam int CTRL_RST_BIT  = 2;
  localparam int XFER_DC_BIT   = 8;
  localparam int XFER_RD_BIT   = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [2:0] CTRL_RESET = 3'h0;

endpackage

// ---- logic/oled_link_if.sv ----
`timescale 1ns/1ps
interface oled_link_if;
  logic       controllerResetN;
  logic       linkSelectLow;
  logic       linkSelectHigh;
  logic       csN;
  logic       dc;
  logic       enRd;
  logic       rwWr;
  logic [7:0] hostOut;
  logic [7:0] hostOe;
  logic [7:0] devOut;
  logic [7:0] devOe;
  logic [7:0] hostByteBus;

  // resolved bus level; undriven lines read low
  genvar i;
  for (i = 0; i < 8; i++) begin : g_wire
    assign hostByteBus[i] = devOe[i] ? devOut[i] :
                            (hostOe[i] & hostOut[i]);
  end

  modport host (
    output controllerResetN, linkSelectLow, linkSelectHigh,
    output csN, dc, enRd, rwWr, hostOut, hostOe,
    input  hostByteBus
  );
  modport device (
    input  controllerResetN, linkSelectLow, linkSelectHigh,
    input  csN, dc, enRd, rwWr, hostByteBus,
    output devOut, devOe
  );
endinterface

// ---- logic/oled_link_device.sv ----
`timescale 1ns/1ps
module oled_link_device
  import oled_link_pkg::*;
(
  // link clock and reset
  input  wire logic       lnkClk,
  input  wire logic       rst,
  // host pins
  oled_link_if.device     pins,
  // user side
  input  wire logic [7:0] rdByte,
  output logic      [7:0] rxByte,
  output logic            rxIsData,
  output logic            rxValid,
  output logic            rdTaken,
  output logic            ctlReset
);

  logic [14:0] meta_ff;
  logic [14:0] sync_ff;
  logic [7:0]  sBus;
  logic        sResN;
  logic        sSelH;
  logic        sSelL;
  logic        sCsN;
  logic        sDc;
  logic        sErd;
  logic        sRww;
  logic [1:0]  mode;
  logic        accNow;
  logic        isRead;
  logic        lastBit;

  logic       accPrev_ff, nxt_accPrev;
  logic       sclkPrev_ff, nxt_sclkPrev;
  logic       rdAcc_ff, nxt_rdAcc;
  logic       oe_ff, nxt_oe;
  logic [7:0] out_ff, nxt_out;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [6:0] shift_ff, nxt_shift;
  logic       dcBit_ff, nxt_dcBit;
  logic [7:0] rxByte_ff, nxt_rxByte;
  logic       rxIsData_ff, nxt_rxIsData;
  logic       rxValid_ff, nxt_rxValid;
  logic       rdTaken_ff, nxt_rdTaken;
  logic       ctlReset_ff, nxt_ctlReset;

  // two-stage synchroniser on every pin
  always_ff @(posedge lnkClk or posedge rst) begin
    if (rst) begin
      meta_ff <= 15'h0;
      sync_ff <= 15'h0;
    end else begin
      meta_ff <= {pins.controllerResetN, pins.linkSelectHigh,
                  pins.linkSelectLow, pins.csN, pins.dc, pins.enRd,
                  pins.rwWr, pins.hostByteBus};
      sync_ff <= meta_ff;
    end
  end

  assign {sResN, sSelH, sSelL, sCsN, sDc, sErd, sRww, sBus} = sync_ff;
  assign mode = {sSelH, sSelL};

  always_comb begin
    accNow = 1'b0;
    isRead = 1'b0;
    if (mode == MODE_P8080) begin
      accNow = ~sCsN & (~sErd | ~sRww);
      isRead = ~sErd;
    end else if (mode == MODE_P6800) begin
      accNow = ~sCsN & sErd;
      isRead = sRww;
    end
    lastBit = (bitCnt_ff == ((mode == MODE_SPI3) ? SPI3_LAST : SPI4_LAST));
  end

  always_comb begin
    nxt_accPrev  = accNow;
    nxt_sclkPrev = sBus[0];
    nxt_rdAcc    = rdAcc_ff;
    nxt_oe       = oe_ff;
    nxt_out      = out_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_shift    = shift_ff;
    nxt_dcBit    = dcBit_ff;
    nxt_rxByte   = rxByte_ff;
    nxt_rxIsData = rxIsData_ff;
    nxt_rxValid  = 1'b0;
    nxt_rdTaken  = 1'b0;
    nxt_ctlReset = ~sResN;
    if (~sResN) begin
      // controller held in initial state
      nxt_accPrev = 1'b0;
      nxt_rdAcc   = 1'b0;
      nxt_oe      = 1'b0;
      nxt_bitCnt  = 4'h0;
      nxt_shift   = 7'h0;
      nxt_dcBit   = 1'b0;
    end else begin
      if (accNow && !accPrev_ff) begin
        nxt_rdAcc = isRead;
        nxt_oe    = isRead;
        nxt_out   = rdByte;
      end
      if (!accNow && accPrev_ff) begin
        nxt_oe = 1'b0;
        if (rdAcc_ff) begin
          nxt_rdTaken = 1'b1;
        end else begin
          nxt_rxValid  = 1'b1;
          nxt_rxByte   = sBus;
          nxt_rxIsData = sDc;
        end
      end
      if (sSelH || sCsN) begin
        nxt_bitCnt = 4'h0;
      end else if (sBus[0] && !sclkPrev_ff) begin
        // rising serial clock on bit 0, data on bit 1
        nxt_bitCnt = bitCnt_ff + 4'h1;
        if (mode == MODE_SPI3 && bitCnt_ff == 4'h0) begin
          nxt_dcBit = sBus[1];
        end else begin
          nxt_shift = {shift_ff[5:0], sBus[1]};
        end
        if (lastBit) begin
          nxt_bitCnt   = 4'h0;
          nxt_rxValid  = 1'b1;
          nxt_rxByte   = {shift_ff, sBus[1]};
          nxt_rxIsData = (mode == MODE_SPI3) ? dcBit_ff : sDc;
        end
      end
    end
  end

  always_ff @(posedge lnkClk or posedge rst) begin
    if (rst) begin
      accPrev_ff  <= 1'b0;
      sclkPrev_ff <= 1'b0;
      rdAcc_ff    <= 1'b0;
      oe_ff       <= 1'b0;
      out_ff      <= 8'h0;
      bitCnt_ff   <= 4'h0;
      shift_ff    <= 7'h0;
      dcBit_ff    <= 1'b0;
      rxByte_ff   <= 8'h0;
      rxIsData_ff <= 1'b0;
      rxValid_ff  <= 1'b0;
      rdTaken_ff  <= 1'b0;
      ctlReset_ff <= 1'b1;
    end else begin
      accPrev_ff  <= nxt_accPrev;
      sclkPrev_ff <= nxt_sclkPrev;
      rdAcc_ff    <= nxt_rdAcc;
      oe_ff       <= nxt_oe;
      out_ff      <= nxt_out;
      bitCnt_ff   <= nxt_bitCnt;
      shift_ff    <= nxt_shift;
      dcBit_ff    <= nxt_dcBit;
      rxByte_ff   <= nxt_rxByte;
      rxIsData_ff <= nxt_rxIsData;
      rxValid_ff  <= nxt_rxValid;
      rdTaken_ff  <= nxt_rdTaken;
      ctlReset_ff <= nxt_ctlReset;
    end
  end

  assign pins.devOut = out_ff;
  assign pins.devOe  = {8{oe_ff}};
  assign rxByte      = rxByte_ff;
  assign rxIsData    = rxIsData_ff;
  assign rxValid     = rxValid_ff;
  assign rdTaken     = rdTaken_ff;
  assign ctlReset    = ctlReset_ff;

endmodule

// ---- logic/oled_link_host.sv ----
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module oled_link_host
  import oled_link_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link pins
  oled_link_if.host        pins,
  // avalon-mm slave
  input  wire logic [1:0]  avAddress,
  input  wire logic        avRead,
  input  wire logic        avWrite,
  input  wire logic [31:0] avWriteData,
  output logic      [31:0] avReadData,
  output logic             avWaitRequest
);

  typedef enum logic [2:0] {
    IDLE, PSETUP, PSTROBE, PHOLD, SLOW, SHIGH
  } host_state_t;
  logic [7:0] busMeta_ff;
  logic [7:0] busSync_ff;
  logic       serial;
  logic       stall;
  logic       take;
  logic       startReq;
  logic       clearDone;
  logic [1:0] mode;
  // bus slave group
  logic        waitReq_ff, nxt_waitReq;
  logic [31:0] rdData_ff, nxt_rdData;
  logic [2:0]  ctrl_ff, nxt_ctrl;
  logic        resN_ff, nxt_resN;
  // engine group
  host_state_t state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [3:0]  bits_ff, nxt_bits;
  logic [8:0]  shift_ff, nxt_shift;
  logic        rdOp_ff, nxt_rdOp;
  logic        done_ff, nxt_done;
  logic [7:0]  rx_ff, nxt_rx;
  logic        csN_ff, nxt_csN;
  logic        dc_ff, nxt_dc;
  logic        enRd_ff, nxt_enRd;
  logic        rwWr_ff, nxt_rwWr;
  logic [7:0]  out_ff, nxt_out;
  logic [7:0]  oe_ff, nxt_oe;
  // returning bus crosses from the device side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busMeta_ff <= 8'h0;
      busSync_ff <= 8'h0;
    end else begin
      busMeta_ff <= pins.hostByteBus;
      busSync_ff <= busMeta_ff;
    end
  end
  assign mode   = ctrl_ff[1:0];
  assign serial = ~mode[1];
  assign take   = ~waitReq_ff;
  assign stall  = avWrite && avAddress == REG_XFER && state_ff != IDLE;
  assign startReq  = take && avWrite && avAddress == REG_XFER;
  assign clearDone = take && avRead && avAddress == REG_RXDATA;
  always_comb begin
    nxt_waitReq = 1'b1;
    nxt_rdData  = rdData_ff;
    nxt_ctrl    = ctrl_ff;
    if (waitReq_ff && (avRead || avWrite) && !stall) begin
      nxt_waitReq = 1'b0;
      nxt_rdData  = 32'h0;
      if (avAddress == REG_CTRL) begin
        nxt_rdData[2:0] = ctrl_ff;
      end else if (avAddress == REG_STATUS) begin
        nxt_rdData[STAT_BUSY_BIT] = (state_ff != IDLE);
        nxt_rdData[STAT_DONE_BIT] = done_ff;
      end else if (avAddress == REG_RXDATA) begin
        nxt_rdData[7:0] = rx_ff;
      end
    end
    if (take && avWrite && avAddress == REG_CTRL) begin
      nxt_ctrl = avWriteData[2:0];
    end
    nxt_resN = ~nxt_ctrl[CTRL_RST_BIT];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitReq_ff <= 1'b1;
      rdData_ff  <= 32'h0;
      ctrl_ff    <= CTRL_RESET;
      resN_ff    <= 1'b1;
    end else begin
      waitReq_ff <= nxt_waitReq;
      rdData_ff  <= nxt_rdData;
      ctrl_ff    <= nxt_ctrl;
      resN_ff    <= nxt_resN;
    end
  end
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_bits  = bits_ff;
    nxt_shift = shift_ff;
    nxt_rdOp  = rdOp_ff;
    nxt_done  = done_ff;
    nxt_rx    = rx_ff;
    nxt_csN   = csN_ff;
    nxt_dc    = dc_ff;
    nxt_enRd  = enRd_ff;
    nxt_rwWr  = rwWr_ff;
    nxt_out   = out_ff;
    nxt_oe    = oe_ff;
    if (clearDone) begin
      nxt_done = 1'b0;
    end
    case (state_ff)
      IDLE: begin
        nxt_csN = 1'b1;
        nxt_cnt = GAP_CYC;
        if (serial) begin
          nxt_enRd = 1'b0;
          nxt_rwWr = 1'b0;
          nxt_out  = 8'h0;
          nxt_oe   = 8'hfb;
          if (mode == MODE_SPI3) begin
            nxt_dc = 1'b0;
          end
        end else begin
          nxt_enRd = (mode == MODE_P8080);
          nxt_rwWr = (mode == MODE_P8080);
          nxt_oe   = 8'h0;
        end
        if (startReq) begin
          nxt_rdOp = avWriteData[XFER_RD_BIT] & ~serial;
          nxt_csN  = 1'b0;
          if (mode != MODE_SPI3) begin
            nxt_dc = avWriteData[XFER_DC_BIT];
          end
          if (serial) begin
            nxt_state = SLOW;
            nxt_cnt   = HALF_CYC;
            if (mode == MODE_SPI3) begin
              // flag first, then byte msb first
              nxt_shift = {avWriteData[XFER_DC_BIT],
                           avWriteData[7:0]};
              nxt_bits  = SPI3_BITS;
            end else begin
              nxt_shift = {avWriteData[7:0], 1'b0};
              nxt_bits  = SPI4_BITS;
            end
          end else begin
            nxt_state = PSETUP;
            nxt_out   = avWriteData[7:0];
            // release the bus for reads
            nxt_oe    = avWriteData[XFER_RD_BIT] ? 8'h0 : 8'hff;
            if (mode == MODE_P6800) begin
              nxt_rwWr = avWriteData[XFER_RD_BIT];
            end
          end
        end
      end
      PSETUP: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = PSTROBE;
          nxt_cnt   = STROBE_CYC;
          if (mode == MODE_P6800) begin
            nxt_enRd = 1'b1;
          end else if (rdOp_ff) begin
            nxt_enRd = 1'b0;
          end else begin
            nxt_rwWr = 1'b0;
          end
        end
      end
      PSTROBE: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = PHOLD;
          nxt_cnt   = GAP_CYC;
          nxt_enRd  = (mode == MODE_P8080);
          nxt_rwWr  = (mode == MODE_P8080) | rdOp_ff;
          nxt_done  = 1'b1;
          if (rdOp_ff) begin
            nxt_rx = busSync_ff;
          end
        end
      end
      SLOW: begin
        nxt_out[1] = shift_ff[8];
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state  = SHIGH;
          nxt_cnt    = HALF_CYC;
          nxt_out[0] = 1'b1;
        end
      end
      SHIGH: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_shift  = {shift_ff[7:0], 1'b0};
          nxt_bits   = bits_ff - 4'h1;
          nxt_out[0] = 1'b0;
          nxt_cnt    = HALF_CYC;
          nxt_state  = SLOW;
          if (bits_ff == 4'h1) begin
            nxt_state = PHOLD;
            nxt_cnt   = GAP_CYC;
            nxt_done  = 1'b1;
          end
        end
      end
      PHOLD: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = IDLE;
          nxt_csN   = 1'b1;
        end
      end
      default: begin
        nxt_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= IDLE;
      cnt_ff   <= 4'h0;
      bits_ff  <= 4'h0;
      shift_ff <= 9'h0;
      rdOp_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rx_ff    <= 8'h0;
      csN_ff   <= 1'b1;
      dc_ff    <= 1'b0;
      enRd_ff  <= 1'b0;
      rwWr_ff  <= 1'b0;
      out_ff   <= 8'h0;
      oe_ff    <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bits_ff  <= nxt_bits;
      shift_ff <= nxt_shift;
      rdOp_ff  <= nxt_rdOp;
      done_ff  <= nxt_done;
      rx_ff    <= nxt_rx;
      csN_ff   <= nxt_csN;
      dc_ff    <= nxt_dc;
      enRd_ff  <= nxt_enRd;
      rwWr_ff  <= nxt_rwWr;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
    end
  end

  assign pins.controllerResetN = resN_ff;
  assign pins.linkSelectLow    = ctrl_ff[0];
  assign pins.linkSelectHigh   = ctrl_ff[1];
  assign pins.csN              = csN_ff;
  assign pins.dc               = dc_ff;
  assign pins.enRd             = enRd_ff;
  assign pins.rwWr             = rwWr_ff;
  assign pins.hostOut          = out_ff;
  assign pins.hostOe           = oe_ff;
  assign avReadData            = rdData_ff;
  assign avWaitRequest         = waitReq_ff;

endmodule

// ---- dv/oled_link_chk.sv ----
`timescale 1ns/1ps
module oled_link_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // link pins
  input wire logic       linkSelectLow,
  input wire logic       linkSelectHigh,
  input wire logic       csN,
  input wire logic       dc,
  input wire logic       enRd,
  input wire logic       rwWr,
  input wire logic [7:0] hostOe,
  input wire logic [7:0] devOe,
  input wire logic [7:0] hostByteBus
);
  logic ser;
  logic p80;
  logic p68;
  assign ser = !linkSelectHigh;
  assign p80 = linkSelectHigh && !linkSelectLow;
  assign p68 = linkSelectHigh && linkSelectLow;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  mode_stable_a: assert property (
    !csN && $past(!csN) |-> $stable({linkSelectHigh, linkSelectLow}))
    else $error("straps moved in transfer");
  strobes_low_a: assert property (
    ser && !csN |-> !enRd && !rwWr) else $error("serial strobes not low");
  dc_low_a: assert property (
    ser && linkSelectLow && !csN |-> !dc) else $error("dc not low");
  pins_tied_a: assert property (
    ser && !csN |-> hostByteBus[7:3] == 5'h00 && !hostOe[2])
    else $error("unused serial lines wrong");
  sclk_select_a: assert property (
    ser && $rose(hostByteBus[0]) |-> !csN) else $error("clock without cs");
  drive_read_a: assert property (
    devOe != 8'h00 |-> !csN && linkSelectHigh) else $error("stray drive");
  read_6800_a: assert property (
    p68 && $rose(devOe[0]) |-> enRd && rwWr) else $error("6800 read bad");
  read_8080_a: assert property (
    p80 && $rose(devOe[0]) |-> !enRd && rwWr) else $error("8080 read bad");
  wr_strobe_a: assert property (
    p80 && $fell(rwWr) |-> !csN [*8] ##[1:20] $rose(rwWr))
    else $error("8080 write strobe bad");
  enable_a: assert property (
    p68 && $rose(enRd) |-> !csN ##[1:20] $fell(enRd))
    else $error("6800 enable bad");
endmodule

// ---- dv/oled_host_interface_select_tb.sv ----
`timescale 1ns/1ps
module oled_host_interface_select_tb import oled_link_pkg::*;;
  logic        ref_clk;
  logic        lnkClk;
  logic        rst;
  logic [1:0]  avAddress;
  logic        avRead;
  logic        avWrite;
  logic [31:0] avWriteData;
  logic [31:0] avReadData;
  logic        avWaitRequest;
  logic [7:0]  rdByte;
  logic [7:0]  rxByte;
  logic        rxIsData;
  logic        rxValid;
  logic        rdTaken;
  logic        ctlReset;
  logic [8:0]  shWord;
  logic [8:0]  rxQ[$];
  int          num_errors;
  int          samples_checked;
  int          seed;
  int          nBits;
  int          nTaken;

  oled_link_if lif();
  oled_link_host oled_link_host_i (.ref_clk(ref_clk), .rst(rst),
    .pins(lif), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWriteData(avWriteData),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest));
  oled_link_device oled_link_device_i (.lnkClk(lnkClk), .rst(rst),
    .pins(lif), .rdByte(rdByte), .rxByte(rxByte), .rxIsData(rxIsData),
    .rxValid(rxValid), .rdTaken(rdTaken), .ctlReset(ctlReset));
  oled_link_chk oled_link_chk_i (.ref_clk(ref_clk), .rst(rst),
    .linkSelectLow(lif.linkSelectLow), .linkSelectHigh(lif.linkSelectHigh),
    .csN(lif.csN), .dc(lif.dc), .enRd(lif.enRd), .rwWr(lif.rwWr),
    .hostOe(lif.hostOe), .devOe(lif.devOe),
    .hostByteBus(lif.hostByteBus));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    lnkClk = 1'b0;
    #13;
    forever #40 lnkClk = ~lnkClk;
  end

  // device user side and serial wire monitors
  always @(posedge lnkClk) begin
    if (rxValid === 1'b1) rxQ.push_back({rxIsData, rxByte});
    if (rdTaken === 1'b1) nTaken++;
  end
  always @(posedge lif.hostByteBus[0]) begin
    if (!lif.linkSelectHigh && !lif.csN) begin
      shWord = {shWord[7:0], lif.hostByteBus[1]};
      nBits++;
    end
  end

  function automatic int exp_bits(input logic [1:0] m);
    return (m == MODE_SPI3) ? 9 : 8;
  endfunction
  function automatic logic [8:0] exp_shift(input logic [1:0] m,
                                           input logic dcv,
                                           input logic [7:0] b);
    return {(m == MODE_SPI3) & dcv, b};
  endfunction

  task automatic conclude();
    $display("errors %0d checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bad(input string what);
    num_errors++;
    $display("BAD %0t %s", $time, what);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
    samples_checked++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic check_count(input int got, input int exp,
                             input string what);
    samples_checked++;
    if (got != exp) bad($sformatf("%s got %0d exp %0d", what, got, exp));
  endtask

  task automatic av(input logic wr, input logic [1:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avAddress   <= a;
    avWrite     <= wr;
    avRead      <= !wr;
    avWriteData <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      bad("bus hang");
      conclude();
    end
    q = avReadData;
    avRead  <= 1'b0;
    avWrite <= 1'b0;
  endtask

  task automatic xfer(input logic [1:0] m, input logic rd,
                      input logic dcv, input logic [7:0] b,
                      input logic [7:0] r);
    logic [31:0] q;
    int n;
    int t0;
    rxQ.delete();
    shWord = 9'h000;
    nBits = 0;
    t0 = nTaken;
    av(1'b1, REG_XFER, {22'h0, rd, dcv, b}, q);
    n = 0;
    do begin
      av(1'b0, REG_STATUS, 32'h0, q);
      n++;
    // wait for the engine to be idle, so straps never move under select
    end while ((q[STAT_DONE_BIT] !== 1'b1 || q[STAT_BUSY_BIT] !== 1'b0)
               && n < 200);
    if (n >= 200) begin
      bad("transfer hang");
      conclude();
    end
    av(1'b0, REG_RXDATA, 32'h0, q);
    n = 0;
    while (rxQ.size() == 0 && nTaken == t0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (!m[1]) begin
      check_count(nBits, exp_bits(m), "bit count");
      check_word(32'(shWord), 32'(exp_shift(m, dcv, b)), "wire");
    end
    if (rd && m[1]) begin
      check_count(nTaken - t0, 1, "read end");
      check_word(q, {24'h0, r}, "read byte");
      check_count(rxQ.size(), 0, "rx on read");
    end else begin
      check_count(rxQ.size(), 1, "rx count");
      if (rxQ.size() > 0)
        check_word(32'(rxQ.pop_front()), {23'h0, dcv, b}, "rx");
    end
  endtask

  initial begin
    logic [31:0] q;
    logic [7:0]  b;
    logic [7:0]  r;
    int          n;
    seed = 8613;
    num_errors = 0;
    samples_checked = 0;
    nBits = 0;
    nTaken = 0;
    shWord = 9'h000;
    rst = 1'b1;
    avAddress = 2'h0;
    avRead = 1'b0;
    avWrite = 1'b0;
    avWriteData = 32'h0;
    rdByte = 8'h00;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    av(1'b0, REG_CTRL, 32'h0, q);
    check_word(q, {29'h0, CTRL_RESET}, "ctrl reset");
    av(1'b0, REG_STATUS, 32'h0, q);
    check_word(q, 32'h0, "status reset");
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      av(1'b1, REG_CTRL, 32'(m), q);
      av(1'b0, REG_CTRL, 32'h0, q);
      check_word(q, 32'(m), "mode");
      for (int k = 0; k < 6; k++) begin
        b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
        r = 8'($random(seed));
        rdByte <= r;
        xfer(2'(m), (k < 2) ? k[0] : 1'($random(seed)),
             1'($random(seed)), b, r);
      end
      $display("test mode %0d done", m);
    end
    av(1'b1, REG_CTRL, 32'h1 << CTRL_RST_BIT, q);
    n = 0;
    while (ctlReset !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    check_word({31'h0, ctlReset}, 32'h1, "ctl reset");
    check_word({31'h0, lif.controllerResetN}, 32'h0, "reset pin");
    av(1'b1, REG_CTRL, 32'(MODE_SPI4), q);
    n = 0;
    while (ctlReset !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    check_word({31'h0, ctlReset}, 32'h0, "ctl run");
    xfer(MODE_SPI4, 1'b0, 1'b1, 8'h5a, 8'h00);
    $display("test controller reset done");
    conclude();
  end
endmodule
